/* File: rtl/pfs_consts.svh */
// Constants for the pad function select and pull-up block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
`define PFS_PD_W 8
`define PFS_PE_W 2
`define PFS_CS_W 6
`define PFS_SER0_TX_BIT 0
`define PFS_SER0_RX_BIT 1
`define PFS_SER1_TX_BIT 6
`define PFS_SER1_RX_BIT 7
`define PFS_PD_SEL_RST 8'hC0
`define PFS_PE_SEL_RST 2'h3
`define PFS_PD_PUR_RST 8'hFF
`define PFS_PE_PUR_RST 2'h3
`define PFS_PD_DIR_RST 8'h00
`define PFS_PE_DIR_RST 2'h0
`define PFS_PD_DAT_RST 8'h00
`define PFS_PE_DAT_RST 2'h0
`define PFS_BUS_DRIVE_CTL_RST 1'h0
`define PFS_TAP_PUD_RST 1'h0
`endif

/* File: rtl/pfs_pkg.sv */
// Types for the pad function select and pull-up block.
// Assumes pfs_consts.svh is on the include path.
`include "pfs_consts.svh"
package pfs_pkg;
  typedef struct packed {
    logic [`PFS_PD_W-1:0] dir;
    logic [`PFS_PD_W-1:0] dat;
    logic [`PFS_PD_W-1:0] sel;
    logic [`PFS_PD_W-1:0] pur;
  } pfs_port_d_s;

  typedef struct packed {
    logic [`PFS_PE_W-1:0] dir;
    logic [`PFS_PE_W-1:0] dat;
    logic [`PFS_PE_W-1:0] sel;
    logic [`PFS_PE_W-1:0] pur;
  } pfs_port_e_s;

  typedef struct packed {
    pfs_port_d_s pd;
    pfs_port_e_s pe;
    logic bus_drive_ctl;
    logic tap_pud;
  } pfs_cfg_s;

  typedef struct packed {
    logic [`PFS_PD_W-1:0] out;
    logic [`PFS_PD_W-1:0] oe;
    logic [`PFS_PD_W-1:0] pu;
  } pfs_pad_d_s;

  typedef struct packed {
    logic [`PFS_PE_W-1:0] out;
    logic [`PFS_PE_W-1:0] oe;
    logic [`PFS_PE_W-1:0] pu;
  } pfs_pad_e_s;
endpackage

/* File: rtl/pfs_top.sv */
// Pad function select, GPIO routing and pull-up control for port D,
// port E and the test-port pads.
// Assumes all inputs synchronous to I_CORE_CLK; pad wires resolved outside.
// Contract
// - Port D pins 0-5 each GPIO input/output
// - Port D 0-5 alternately carry selects two-seven
// - Selects tri-stated on idle bus per drive bit
// - Reset picks GPIO on port D 0-5
// - Port D pull-up off when its bit cleared
// - Serial0 transmit shares port E 0, default
// - Port E bit 0 clear disables pull-up
// - Serial0 receive shares port E 1, input, pulled
// - Port E bit 1 clear disables pull-up
// - Serial1 transmit on port D 6, default
// - Serial1 receive on port D 7, default
// - Port D bit 7 clear disables pull-up
// - Test-port bit set disables mode/data pull-ups
// - Test clock pad has internal pull-down
// - Test output driven only in shift, falling edge
// - Bus drive bit lives in bus control register
`timescale 1ns/1ns
`include "pfs_consts.svh"
module pfs_top
  import pfs_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_CFG_WE,
  input wire pfs_cfg_s I_CFG,
  output pfs_cfg_s O_CFG,
  input wire logic [`PFS_PD_W-1:0] I_PD_PAD,
  output pfs_pad_d_s O_PD,
  output logic [`PFS_PD_W-1:0] O_PD_GPIO_IN,
  input wire logic [`PFS_PE_W-1:0] I_PE_PAD,
  output pfs_pad_e_s O_PE,
  output logic [`PFS_PE_W-1:0] O_PE_GPIO_IN,
  input wire logic [`PFS_CS_W-1:0] I_EXT_SEL_N,
  input wire logic I_EXT_BUS_ACTIVE,
  input wire logic I_SER0_TXD,
  output logic O_SER0_RXD,
  input wire logic I_SER1_TXD,
  output logic O_SER1_RXD,
  input wire logic I_TCK_PAD,
  input wire logic I_TAP_SHIFT,
  input wire logic I_TAP_TDO,
  output logic O_TDO_PAD,
  output logic O_TDO_OE,
  output logic O_TCK_PD,
  output logic O_TMS_PU,
  output logic O_TDI_PU
);

  function automatic logic pick(input logic periph_sel, input logic periph,
                                input logic gpio);
    return periph_sel ? periph : gpio;
  endfunction

  pfs_cfg_s cfg_ff;
  pfs_cfg_s nxt_cfg;
  pfs_pad_d_s pad_d_ff;
  pfs_pad_d_s nxt_pad_d;
  pfs_pad_e_s pad_e_ff;
  pfs_pad_e_s nxt_pad_e;
  logic [`PFS_PD_W-1:0] gpio_d_ff;
  logic [`PFS_PE_W-1:0] gpio_e_ff;
  logic ser0_rxd_ff;
  logic ser1_rxd_ff;
  logic tck_ff;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic nxt_tdo;
  logic nxt_tdo_oe;
  logic tck_fall;
  logic cs_oe;
  logic nxt_ser0_rxd;
  logic nxt_ser1_rxd;
  logic [`PFS_PD_W-1:0] periph_out_d;
  logic [`PFS_PD_W-1:0] periph_oe_d;
  logic [`PFS_PE_W-1:0] periph_out_e;
  logic [`PFS_PE_W-1:0] periph_oe_e;

  // Drive bit sits with the bus control settings in the config word
  assign nxt_cfg = I_CFG_WE ? I_CFG : cfg_ff;

  // Zero keeps selects floating between bus cycles; one drives them always
  assign cs_oe = cfg_ff.bus_drive_ctl | I_EXT_BUS_ACTIVE;

  // Receive pad never drives; its out bit idles high
  assign periph_out_d = {1'b1, I_SER1_TXD, I_EXT_SEL_N};
  assign periph_oe_d = {1'b0, 1'b1, {`PFS_CS_W{cs_oe}}};
  assign periph_out_e = {1'b1, I_SER0_TXD};
  assign periph_oe_e = {1'b0, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < `PFS_PD_W; gi++) begin : g_pd
      assign nxt_pad_d.out[gi] = pick(cfg_ff.pd.sel[gi], periph_out_d[gi],
                                      cfg_ff.pd.dat[gi]);
      assign nxt_pad_d.oe[gi] = pick(cfg_ff.pd.sel[gi], periph_oe_d[gi],
                                     cfg_ff.pd.dir[gi]);
    end
    for (gi = 0; gi < `PFS_PE_W; gi++) begin : g_pe
      assign nxt_pad_e.out[gi] = pick(cfg_ff.pe.sel[gi], periph_out_e[gi],
                                      cfg_ff.pe.dat[gi]);
      assign nxt_pad_e.oe[gi] = pick(cfg_ff.pe.sel[gi], periph_oe_e[gi],
                                     cfg_ff.pe.dir[gi]);
    end
  endgenerate

  // Pull-up follows its register bit whatever function owns the pad
  assign nxt_pad_d.pu = cfg_ff.pd.pur;
  assign nxt_pad_e.pu = cfg_ff.pe.pur;

  // Receivers see idle high when the pad is handed to GPIO
  assign nxt_ser0_rxd = cfg_ff.pe.sel[`PFS_SER0_RX_BIT] ?
                        I_PE_PAD[`PFS_SER0_RX_BIT] : 1'b1;
  assign nxt_ser1_rxd = cfg_ff.pd.sel[`PFS_SER1_RX_BIT] ?
                        I_PD_PAD[`PFS_SER1_RX_BIT] : 1'b1;

  // Test clock is sampled, so its edge is seen one core cycle late
  assign tck_fall = tck_ff & ~I_TCK_PAD;
  assign nxt_tdo = tck_fall ? I_TAP_TDO : tdo_ff;
  assign nxt_tdo_oe = tck_fall ? I_TAP_SHIFT : tdo_oe_ff;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      cfg_ff.pd.dir <= `PFS_PD_DIR_RST;
      cfg_ff.pd.dat <= `PFS_PD_DAT_RST;
      cfg_ff.pd.sel <= `PFS_PD_SEL_RST;
      cfg_ff.pd.pur <= `PFS_PD_PUR_RST;
      cfg_ff.pe.dir <= `PFS_PE_DIR_RST;
      cfg_ff.pe.dat <= `PFS_PE_DAT_RST;
      cfg_ff.pe.sel <= `PFS_PE_SEL_RST;
      cfg_ff.pe.pur <= `PFS_PE_PUR_RST;
      cfg_ff.bus_drive_ctl <= `PFS_BUS_DRIVE_CTL_RST;
      cfg_ff.tap_pud <= `PFS_TAP_PUD_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      pad_d_ff <= '{out: '0, oe: '0, pu: '1};
      pad_e_ff <= '{out: '0, oe: '0, pu: '1};
    end else begin
      pad_d_ff <= nxt_pad_d;
      pad_e_ff <= nxt_pad_e;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      gpio_d_ff <= '0;
      gpio_e_ff <= '0;
      ser0_rxd_ff <= 1'b1;
      ser1_rxd_ff <= 1'b1;
    end else begin
      gpio_d_ff <= I_PD_PAD;
      gpio_e_ff <= I_PE_PAD;
      ser0_rxd_ff <= nxt_ser0_rxd;
      ser1_rxd_ff <= nxt_ser1_rxd;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      tck_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tck_ff <= I_TCK_PAD;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign O_CFG = cfg_ff;
  assign O_PD = pad_d_ff;
  assign O_PE = pad_e_ff;
  assign O_PD_GPIO_IN = gpio_d_ff;
  assign O_PE_GPIO_IN = gpio_e_ff;
  assign O_SER0_RXD = ser0_rxd_ff;
  assign O_SER1_RXD = ser1_rxd_ff;
  assign O_TDO_PAD = tdo_ff;
  assign O_TDO_OE = tdo_oe_ff;
  // Pull-down is fixed; software has no control over it
  assign O_TCK_PD = 1'b1;
  assign O_TMS_PU = ~cfg_ff.tap_pud;
  assign O_TDI_PU = ~cfg_ff.tap_pud;

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RESET);

  a_gpio_dir_out: assert property (
    !cfg_ff.pd.sel[3] |=> O_PD.oe[3] == $past(cfg_ff.pd.dir[3])
                          && O_PD.out[3] == $past(cfg_ff.pd.dat[3]))
    else $error("Port D GPIO pad does not follow direction or data");

  a_cs_route_out: assert property (
    cfg_ff.pd.sel[2] |=> O_PD.out[2] == $past(I_EXT_SEL_N[2]))
    else $error("External select not routed to port D pad");

  a_cs_idle_float: assert property (
    cfg_ff.pd.sel[0] && !cfg_ff.bus_drive_ctl && !I_EXT_BUS_ACTIVE |=> !O_PD.oe[0])
    else $error("Select driven on idle bus with drive bit clear");

  a_cs_drive_holds: assert property (
    cfg_ff.pd.sel[5] && cfg_ff.bus_drive_ctl |=> O_PD.oe[5])
    else $error("Select not driven with drive bit set");

  a_reset_sel_gpio: assert property (
    @(posedge I_CORE_CLK) $fell(I_RESET) |->
      cfg_ff.pd.sel == `PFS_PD_SEL_RST && cfg_ff.pe.sel == `PFS_PE_SEL_RST)
    else $error("Pad functions wrong after reset");

  a_pd_pullup_bits: assert property (
    1'b1 |=> O_PD.pu == $past(cfg_ff.pd.pur))
    else $error("Port D pull-up does not follow its register");

  a_pe_pullup_bits: assert property (
    1'b1 |=> O_PE.pu == $past(cfg_ff.pe.pur))
    else $error("Port E pull-up does not follow its register");

  a_ser0_tx_pad: assert property (
    cfg_ff.pe.sel[0] |=> O_PE.oe[0] && O_PE.out[0] == $past(I_SER0_TXD))
    else $error("Serial 0 transmit not on its pad");

  a_ser0_rx_pad: assert property (
    cfg_ff.pe.sel[1] |=> !O_PE.oe[1] && O_SER0_RXD == $past(I_PE_PAD[1]))
    else $error("Serial 0 receive pad wrong");

  a_ser1_tx_pad: assert property (
    cfg_ff.pd.sel[6] |=> O_PD.oe[6] && O_PD.out[6] == $past(I_SER1_TXD))
    else $error("Serial 1 transmit not on its pad");

  a_ser1_rx_pad: assert property (
    cfg_ff.pd.sel[7] |=> !O_PD.oe[7] && O_SER1_RXD == $past(I_PD_PAD[7]))
    else $error("Serial 1 receive pad wrong");

  a_tap_pull_off: assert property (
    I_CFG_WE && I_CFG.tap_pud |=> !O_TMS_PU && !O_TDI_PU)
    else $error("Test-port pull-ups still on after disable");

  a_tdo_fall_only: assert property (
    !(tck_ff && !I_TCK_PAD) |=> $stable(O_TDO_OE) && $stable(O_TDO_PAD))
    else $error("Test output changed without falling test clock");

  a_tdo_shift_en: assert property (
    tck_ff && !I_TCK_PAD |=> O_TDO_OE == $past(I_TAP_SHIFT)
                             && O_TDO_PAD == $past(I_TAP_TDO))
    else $error("Test output enable not taken at falling edge");

  // Reset would mask this check, so the default disable is overridden
  a_reset_pads_off: assert property (
    @(posedge I_CORE_CLK) disable iff (1'b0)
      I_RESET |=> O_PD.oe == '0 && O_PE.oe == '0 && &O_PD.pu && &O_PE.pu && !O_TDO_OE)
    else $error("Pad drivers on or pull-ups off in reset");

  a_cs_busy_drive: assert property (
    cfg_ff.pd.sel[4] && I_EXT_BUS_ACTIVE |=> O_PD.oe[4])
    else $error("Select not driven during a bus cycle");

  a_gpio_dir_all: assert property (
    (cfg_ff.pd.sel & 8'h3F) == 8'h00
      |=> (O_PD.oe & 8'h3F) == ($past(cfg_ff.pd.dir) & 8'h3F))
    else $error("Port D GPIO directions not applied");

  a_pe_gpio_dir: assert property (
    !cfg_ff.pe.sel[0] |=> O_PE.oe[0] == $past(cfg_ff.pe.dir[0])
                          && O_PE.out[0] == $past(cfg_ff.pe.dat[0]))
    else $error("Port E GPIO pad does not follow direction or data");

  a_gpio_in_delay: assert property (
    1'b1 |=> O_PD_GPIO_IN == $past(I_PD_PAD) && O_PE_GPIO_IN == $past(I_PE_PAD))
    else $error("GPIO input not one cycle behind its pad");

  a_ser0_rx_idle: assert property (
    !cfg_ff.pe.sel[1] |=> O_SER0_RXD)
    else $error("Serial 0 receive not idle with pad on GPIO");

  a_ser1_rx_idle: assert property (
    !cfg_ff.pd.sel[7] |=> O_SER1_RXD)
    else $error("Serial 1 receive not idle with pad on GPIO");

  a_cfg_load: assert property (
    I_CFG_WE |=> O_CFG == $past(I_CFG))
    else $error("Config write not taken");

  a_cfg_hold: assert property (
    !I_CFG_WE |=> $stable(O_CFG))
    else $error("Config changed without a write");

  a_tap_pull_on: assert property (
    I_CFG_WE && !I_CFG.tap_pud |=> O_TMS_PU && O_TDI_PU)
    else $error("Test-port pull-ups off while enabled");

  c_cs_driven: cover property (cfg_ff.pd.sel[0] && I_EXT_BUS_ACTIVE ##1 O_PD.oe[0]);
  c_cs_float: cover property (cfg_ff.pd.sel[1] && !cs_oe ##1 !O_PD.oe[1]);
  c_tdo_on: cover property (tck_fall && I_TAP_SHIFT ##1 O_TDO_OE);
  c_ser1_to_gpio: cover property (I_CFG_WE && !I_CFG.pd.sel[6] ##2 !O_PD.oe[6]);

endmodule

/* File: testbench/pfs_pad_model.sv */
// Pad and pin model standing outside the pad function select block.
// Assumes the bench drives the external levels and enables.
`timescale 1ns/1ns
module pfs_pad_model
  import pfs_pkg::*;
(
  input wire logic i_clk,
  input wire pfs_pad_d_s i_pd,
  input wire pfs_pad_e_s i_pe,
  input wire logic [9:0] i_ext_en,
  input wire logic [9:0] i_ext_val,
  input wire logic i_tck_en,
  input wire logic i_tck_val,
  input wire logic i_tck_pd,
  output logic [7:0] o_pd_pad,
  output logic [1:0] o_pe_pad,
  output logic o_tck_pad
);
  // Floating pads toggle so a stale value never reads as valid
  logic flt = 1'b0;
  logic [9:0] lvl;
  wire [9:0] oe = {i_pe.oe, i_pd.oe};
  wire [9:0] out = {i_pe.out, i_pd.out};
  wire [9:0] pu = {i_pe.pu, i_pd.pu};
  always @(posedge i_clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      lvl[i] = oe[i] ? out[i] : i_ext_en[i] ? i_ext_val[i] : pu[i] ? 1'b1 : flt;
    end
  end
  assign o_pd_pad = lvl[7:0];
  assign o_pe_pad = lvl[9:8];
  assign o_tck_pad = i_tck_en ? i_tck_val : (i_tck_pd ? 1'b0 : flt);
endmodule

/* File: testbench/tb_pfs_top.sv */
// Self-checking bench for pfs_top with a cycle model of pads and config.
// Assumes the pad model resolves every pad level fed back to the design.
`timescale 1ns/1ns
`include "pfs_consts.svh"
module tb_pfs_top;
  import pfs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, bus = 1'b0, tx0 = 1'b0, tx1 = 1'b0;
  logic shift = 1'b0, tdo = 1'b0, tck_en = 1'b0, tck_val = 1'b0, tck_q = 1'b0, started = 1'b0;
  logic [5:0] sel_n = 6'h3F;
  logic [9:0] ext_en = 10'h000, ext_val = 10'h000;
  pfs_cfg_s cfg_in = '0, cfg_out, mcfg;
  pfs_pad_d_s pd, e_pd;
  pfs_pad_e_s pe, e_pe;
  logic [7:0] pd_pad, gd_in, e_gd;
  logic [1:0] pe_pad, ge_in, e_ge, e_rx, e_tdo;
  logic rx0, rx1, tdo_pad, tdo_oe, tck_pd, tms_pu, tdi_pu, tck_pad;
  int fails = 0, num_checks = 0;
  always #4 clk = ~clk;
  pfs_top i_pfs_top (.I_CORE_CLK(clk), .I_RESET(rst), .I_CFG_WE(we), .I_CFG(cfg_in),
    .O_CFG(cfg_out), .I_PD_PAD(pd_pad), .O_PD(pd), .O_PD_GPIO_IN(gd_in), .I_PE_PAD(pe_pad),
    .O_PE(pe), .O_PE_GPIO_IN(ge_in), .I_EXT_SEL_N(sel_n), .I_EXT_BUS_ACTIVE(bus),
    .I_SER0_TXD(tx0), .O_SER0_RXD(rx0), .I_SER1_TXD(tx1), .O_SER1_RXD(rx1),
    .I_TCK_PAD(tck_pad), .I_TAP_SHIFT(shift), .I_TAP_TDO(tdo), .O_TDO_PAD(tdo_pad),
    .O_TDO_OE(tdo_oe), .O_TCK_PD(tck_pd), .O_TMS_PU(tms_pu), .O_TDI_PU(tdi_pu));
  pfs_pad_model i_pfs_pad_model (.i_clk(clk), .i_pd(pd), .i_pe(pe), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .i_tck_en(tck_en), .i_tck_val(tck_val), .i_tck_pd(tck_pd),
    .o_pd_pad(pd_pad), .o_pe_pad(pe_pad), .o_tck_pad(tck_pad));
  // Reference model: what each output must hold after this edge
  always @(posedge clk) begin
    started = 1'b1;
    if (rst) begin
      e_pd = {8'h00, 8'h00, 8'hFF};
      e_pe = {2'h0, 2'h0, 2'h3};
      {e_gd, e_ge, e_rx, e_tdo} = {8'h00, 2'h0, 2'h3, 2'h0};
      mcfg = {`PFS_PD_DIR_RST, `PFS_PD_DAT_RST, `PFS_PD_SEL_RST, `PFS_PD_PUR_RST,
        `PFS_PE_DIR_RST, `PFS_PE_DAT_RST, `PFS_PE_SEL_RST, `PFS_PE_PUR_RST,
        `PFS_BUS_DRIVE_CTL_RST, `PFS_TAP_PUD_RST};
    end else begin
      for (int i = 0; i < 8; i++) begin
        {e_pd.out[i], e_pd.oe[i]} = {mcfg.pd.dat[i], mcfg.pd.dir[i]};
        if (mcfg.pd.sel[i]) begin
          if (i < 6) {e_pd.out[i], e_pd.oe[i]} = {sel_n[i], mcfg.bus_drive_ctl | bus};
          else {e_pd.out[i], e_pd.oe[i]} = {tx1, i == 6};
        end
      end
      for (int i = 0; i < 2; i++) begin
        {e_pe.out[i], e_pe.oe[i]} = {mcfg.pe.dat[i], mcfg.pe.dir[i]};
        if (mcfg.pe.sel[i]) {e_pe.out[i], e_pe.oe[i]} = {tx0, i == 0};
      end
      {e_pd.pu, e_pe.pu, e_gd, e_ge} = {mcfg.pd.pur, mcfg.pe.pur, pd_pad, pe_pad};
      e_rx = {mcfg.pd.sel[7] ? pd_pad[7] : 1'b1, mcfg.pe.sel[1] ? pe_pad[1] : 1'b1};
      if (tck_q && !tck_pad) e_tdo = {shift, tdo};
      if (we) mcfg = cfg_in;
    end
    tck_q = tck_pad;
  end
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input logic r);
    @(negedge clk);
    if (started) begin
      chk("pd_oe", pd.oe, e_pd.oe);
      chk("pd_out", pd.out & e_pd.oe, e_pd.out & e_pd.oe);
      chk("pd_pu", pd.pu, e_pd.pu);
      chk("pe_oe", pe.oe, e_pe.oe);
      chk("pe_out", pe.out & e_pe.oe, e_pe.out & e_pe.oe);
      chk("pe_pu", pe.pu, e_pe.pu);
      chk("cfg", cfg_out, mcfg);
      chk("gpio_in", {ge_in, gd_in}, {e_ge, e_gd});
      chk("rxd", {rx1, rx0}, e_rx);
      chk("tdo", {tdo_oe, tdo_pad}, e_tdo);
      chk("test_pulls", {tck_pd, tms_pu, tdi_pu}, {1'b1, {2{~mcfg.tap_pud}}});
    end
    // Test clock held low in reset so both sides agree on its last sample
    {rst, tck_en, tck_val} = {r, r ? 2'b00 : 2'($urandom)};
    {sel_n, bus, tx0, tx1, shift, tdo} = 11'($urandom);
    {ext_en, ext_val} = 20'($urandom);
    we = ($urandom % 4) == 0;
    cfg_in = pfs_cfg_s'(42'({$urandom, $urandom}));
    if ($urandom % 2) cfg_in.bus_drive_ctl = 1'b1;
  endtask
  initial begin
    void'($urandom(32'hA93D6A7A));
    repeat (8) cyc(1'b1);
    for (int n = 0; n < 2000; n++) cyc(n >= 900 && n < 903);
    wrap_up();
  end
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule
